// [rtl/mpst_defs.svh]
`ifndef MPST_DEFS_SVH
`define MPST_DEFS_SVH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define MPST_CLK_NS          10
`define MPST_CLKP_NS_100     40
`define MPST_CLKP_NS_10      400
`define MPST_BIT_NS_100      10
`define MPST_BIT_NS_10       100
`define MPST_BIT_CYC_100     (`MPST_BIT_NS_100 / `MPST_CLK_NS)
`define MPST_BIT_CYC_10      (`MPST_BIT_NS_10 / `MPST_CLK_NS)
`define MPST_MDIO_VALID_NS   300
`define MPST_MDIO_VALID_CYC  (`MPST_MDIO_VALID_NS / `MPST_CLK_NS)

// ----------------------------------------------------------------------
// Synchronised pin vector layout
// ----------------------------------------------------------------------
`define MPST_SY_W            13
`define MPST_SY_TXD          3:0
`define MPST_SY_TXEN         4
`define MPST_SY_TXER         5
`define MPST_SY_LRXB         6
`define MPST_SY_LRXA         7
`define MPST_SY_LRXE         8
`define MPST_SY_MDC          9
`define MPST_SY_MDIO         10
`define MPST_SY_S100         11
`define MPST_SY_HDX          12

// ----------------------------------------------------------------------
// Management frame
// ----------------------------------------------------------------------
`define MPST_PRE_LEN         6'h20
`define MPST_HDR_LAST        6'h0C
`define MPST_RD_LAST         6'h10
`define MPST_WR_LAST         6'h10
`define MPST_OP_READ         2'h2
`define MPST_STAT_PAD        11'h000

`endif

// [rtl/mpst_pkg.sv]
`default_nettype none

package mpst_pkg;

	// Management port states
	typedef enum logic [3:0] {
		MPST_M_HUNT = 4'h1,
		MPST_M_HDR  = 4'h2,
		MPST_M_TA   = 4'h4,
		MPST_M_DATA = 4'h8
	} mpst_mstate_t;

	// Whole state of the top module
	typedef struct packed {
		logic [3:0]   div_cnt;
		logic [1:0]   tx_ph;
		logic         tx_clk;
		logic [3:0]   tx_sh;
		logic         tx_frame;
		logic         ltx_bit;
		logic         ltx_en;
		logic         ltx_err;
		logic [1:0]   rx_ph;
		logic         rx_clk;
		logic         rx_busy;
		logic [1:0]   rx_cnt;
		logic [3:0]   rx_sh;
		logic         rx_err;
		logic [3:0]   rxd;
		logic         rx_dv;
		logic         rx_er;
		logic         crs;
		logic         mdc_d;
		mpst_mstate_t mst;
		logic [5:0]   mcnt;
		logic         mrd;
		logic [15:0]  msh;
		logic         mdio_o;
		logic         mdio_oe;
	} mpst_state_t;

endpackage

`default_nettype wire

// [rtl/mpst_sync.sv]
`default_nettype none

module mpst_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         i_mclk,
	input  wire logic         i_rst,
	// Asynchronous in, synchronised out
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_sync
);

	typedef struct packed {
		logic [W-1:0] s2;
		logic [W-1:0] s1;
	} mpst_sync_st_t;

	mpst_sync_st_t st_r;
	mpst_sync_st_t st_nxt;

	// First stage feeds only the second, to let metastability settle
	always_comb begin
		st_nxt    = st_r;
		st_nxt.s1 = i_async;
		st_nxt.s2 = st_r.s1;
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign o_sync = st_r.s2;

endmodule

`default_nettype wire

// [rtl/mpst_top.sv]
// Overview of operation
// - The receive clock runs at 40 ns per period at 100 Mb/s and 400 ns at 10 Mb/s.
// - Receive nibble, valid and error change only on the receive clock fall, stable at its rise.
// - Read data on the management line changes after a clock rise, valid within 300 ns; writes sample there.
// - At 10 Mb/s received preamble reaches the receive nibble within 7 bit times of its first line bit.
// - At 10 Mb/s the first bit of a sampled transmit nibble reaches the line within 2 bit times.
// - At 100 Mb/s the first start delimiter bit reaches the line within 3 bit times of enable sampled.
// - At 100 Mb/s half duplex, carrier sense rises 0 to 4 bit times after enable is sampled.
// - In half duplex carrier sense falls within 0 to 4 bit times of transmit enable falling.
// - At 10 Mb/s half duplex, carrier sense rises within 2 bit times of transmit enable rising.
// - The transmit clock runs at 40 ns per period at 100 Mb/s and 400 ns at 10 Mb/s.
// - A bit time at 10 Mb/s is 100 ns.
`include "mpst_defs.svh"
`default_nettype none

module mpst_top (
	// Clock and reset
	input  wire logic       i_mclk,
	input  wire logic       i_rst,
	// Mode pins
	input  wire logic       i_speed_100,
	input  wire logic       i_half_duplex,
	// MII transmit
	output logic            o_tx_clk,
	input  wire logic [3:0] i_txd,
	input  wire logic       i_tx_en,
	input  wire logic       i_tx_er,
	// MII receive
	output logic            o_rx_clk,
	output logic      [3:0] o_rxd,
	output logic            o_rx_dv,
	output logic            o_rx_er,
	output logic            o_crs,
	// Line side
	output logic            o_line_transmit_pair,
	output logic            o_line_transmit_pair_en,
	output logic            o_line_transmit_pair_err,
	input  wire logic       i_line_receive_pair,
	input  wire logic       i_line_receive_pair_act,
	input  wire logic       i_line_receive_pair_err,
	// Management port
	input  wire logic       i_mdc,
	input  wire logic       i_mdio_i,
	output logic            o_mdio_o,
	output logic            o_mdio_oe
);

	// ------------------------------------------------------------------
	// Constants
	// ------------------------------------------------------------------
	localparam logic [3:0] DIV_100 = 4'(`MPST_BIT_CYC_100 - 1);
	localparam logic [3:0] DIV_10  = 4'(`MPST_BIT_CYC_10 - 1);
	localparam int HALF_10  = `MPST_CLKP_NS_10 / 2 / `MPST_CLK_NS;
	localparam int MDIO_CYC = `MPST_MDIO_VALID_CYC;

	// ------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------
	logic [`MPST_SY_W-1:0] sy;

	mpst_sync #(
		.W (`MPST_SY_W)
	) u_sync (
		.i_mclk  (i_mclk),
		.i_rst   (i_rst),
		.i_async ({i_half_duplex, i_speed_100, i_mdio_i, i_mdc,
			i_line_receive_pair_err, i_line_receive_pair_act,
			i_line_receive_pair, i_tx_er, i_tx_en, i_txd}),
		.o_sync  (sy)
	);

	logic [3:0] txd_s;
	logic       tx_en_s;
	logic       tx_er_s;
	logic       lrb_s;
	logic       lra_s;
	logic       lre_s;
	logic       mdc_s;
	logic       mdio_s;
	logic       s100_s;
	logic       hdx_s;

	assign txd_s   = sy[`MPST_SY_TXD];
	assign tx_en_s = sy[`MPST_SY_TXEN];
	assign tx_er_s = sy[`MPST_SY_TXER];
	assign lrb_s   = sy[`MPST_SY_LRXB];
	assign lra_s   = sy[`MPST_SY_LRXA];
	assign lre_s   = sy[`MPST_SY_LRXE];
	assign mdc_s   = sy[`MPST_SY_MDC];
	assign mdio_s  = sy[`MPST_SY_MDIO];
	assign s100_s  = sy[`MPST_SY_S100];
	assign hdx_s   = sy[`MPST_SY_HDX];

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	mpst_pkg::mpst_state_t st_r;
	mpst_pkg::mpst_state_t st_nxt;
	logic                  bit_en;
	logic                  tx_take;
	logic                  mdc_rise;

	// One bit time per enable; speed pin is assumed static during frames
	assign bit_en   = (st_r.div_cnt == (s100_s ? DIV_100 : DIV_10));
	assign tx_take  = bit_en && (st_r.tx_ph == 2'h3);
	assign mdc_rise = mdc_s && !st_r.mdc_d;

	// Next-state logic
	always_comb begin
		st_nxt = st_r;
		st_nxt.div_cnt = bit_en ? 4'h0 : st_r.div_cnt + 4'h1;
		if (bit_en) begin
			// Four bit times per clock, high for the first two
			st_nxt.tx_ph  = st_r.tx_ph + 2'h1;
			st_nxt.tx_clk = !st_nxt.tx_ph[1];
			if (st_nxt.tx_ph == 2'h0) begin
				// Clock rise: take the nibble and start the line at once
				st_nxt.tx_frame = tx_en_s;
				st_nxt.tx_sh    = txd_s;
				st_nxt.ltx_bit  = txd_s[0] & tx_en_s;
				st_nxt.ltx_en   = tx_en_s;
				st_nxt.ltx_err  = tx_en_s & tx_er_s;
			end else begin
				st_nxt.ltx_bit = st_r.tx_sh[st_nxt.tx_ph] & st_r.ltx_en;
			end
			// Receive deserialiser, least significant bit first
			st_nxt.rx_ph = st_r.rx_ph + 2'h1;
			if (!st_r.rx_busy) begin
				if (lra_s) begin
					// Realign receive clock so the first nibble lands at once
					st_nxt.rx_busy = 1'b1;
					st_nxt.rx_sh   = {lrb_s, st_r.rx_sh[3:1]};
					st_nxt.rx_cnt  = 2'h1;
					st_nxt.rx_ph   = 2'h3;
					st_nxt.rx_err  = lre_s;
				end
			end else begin
				st_nxt.rx_sh   = {lrb_s, st_r.rx_sh[3:1]};
				st_nxt.rx_cnt  = st_r.rx_cnt + 2'h1;
				st_nxt.rx_err  = st_r.rx_err | lre_s;
				st_nxt.rx_busy = lra_s;
			end
			st_nxt.rx_clk = !st_nxt.rx_ph[1];
			// Outputs move only as the receive clock falls
			if (st_nxt.rx_ph == 2'h2) begin
				if (st_r.rx_busy && lra_s && (st_r.rx_cnt == 2'h3)) begin
					st_nxt.rxd    = st_nxt.rx_sh;
					st_nxt.rx_dv  = 1'b1;
					st_nxt.rx_er  = st_nxt.rx_err;
					st_nxt.rx_err = 1'b0;
				end else begin
					st_nxt.rx_dv = 1'b0;
					st_nxt.rx_er = 1'b0;
				end
			end
		end
		// Fast path keeps 100M assertion after sampling, 10M on the raw level
		st_nxt.crs = (hdx_s & (s100_s ? (st_r.tx_frame & tx_en_s) : tx_en_s))
			| lra_s;
		// Management port, acting only on clock rises
		st_nxt.mdc_d = mdc_s;
		if (mdc_rise) begin
			unique case (st_r.mst)
				mpst_pkg::MPST_M_HUNT: begin
					if (mdio_s) begin
						if (st_r.mcnt != `MPST_PRE_LEN) begin
							st_nxt.mcnt = st_r.mcnt + 6'h01;
						end
					end else begin
						if (st_r.mcnt == `MPST_PRE_LEN) begin
							st_nxt.mst = mpst_pkg::MPST_M_HDR;
						end
						st_nxt.mcnt = 6'h00;
					end
				end
				mpst_pkg::MPST_M_HDR: begin
					st_nxt.msh  = {st_r.msh[14:0], mdio_s};
					st_nxt.mcnt = st_r.mcnt + 6'h01;
					if (st_r.mcnt == `MPST_HDR_LAST) begin
						st_nxt.mrd  = (st_nxt.msh[11:10] == `MPST_OP_READ);
						st_nxt.mcnt = 6'h00;
						st_nxt.mst  = st_nxt.msh[12] ? mpst_pkg::MPST_M_TA
							: mpst_pkg::MPST_M_HUNT;
					end
				end
				mpst_pkg::MPST_M_TA: begin
					// Reads answer with the block's live status
					if (st_r.mrd) begin
						st_nxt.mdio_oe = 1'b1;
						st_nxt.mdio_o  = 1'b0;
						st_nxt.msh     = {s100_s, hdx_s, st_r.crs, st_r.rx_dv,
							st_r.tx_frame, `MPST_STAT_PAD};
					end
					st_nxt.mst = mpst_pkg::MPST_M_DATA;
				end
				mpst_pkg::MPST_M_DATA: begin
					st_nxt.mcnt = st_r.mcnt + 6'h01;
					if (st_r.mrd) begin
						if (st_r.mcnt == `MPST_RD_LAST) begin
							st_nxt.mdio_oe = 1'b0;
							st_nxt.mdio_o  = 1'b0;
							st_nxt.mcnt    = 6'h00;
							st_nxt.mst     = mpst_pkg::MPST_M_HUNT;
						end else begin
							st_nxt.mdio_o = st_r.msh[15];
							st_nxt.msh    = {st_r.msh[14:0], 1'b0};
						end
					end else if (st_r.mcnt == `MPST_WR_LAST) begin
						// Written data is not stored: no registers behind it
						st_nxt.mcnt = 6'h00;
						st_nxt.mst  = mpst_pkg::MPST_M_HUNT;
					end
				end
				default: begin
					st_nxt.mst = mpst_pkg::MPST_M_HUNT;
				end
			endcase
		end
	end

	// State register
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			st_r       <= '0;
			st_r.mst   <= mpst_pkg::MPST_M_HUNT;
			// Phases park just before a rise, so the first high phase is whole
			st_r.tx_ph <= 2'h3;
			st_r.rx_ph <= 2'h3;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Outputs straight from the state register
	assign o_tx_clk                 = st_r.tx_clk;
	assign o_rx_clk                 = st_r.rx_clk;
	assign o_rxd                    = st_r.rxd;
	assign o_rx_dv                  = st_r.rx_dv;
	assign o_rx_er                  = st_r.rx_er;
	assign o_crs                    = st_r.crs;
	assign o_line_transmit_pair     = st_r.ltx_bit;
	assign o_line_transmit_pair_en  = st_r.ltx_en;
	assign o_line_transmit_pair_err = st_r.ltx_err;
	assign o_mdio_o                 = st_r.mdio_o;
	assign o_mdio_oe                = st_r.mdio_oe;

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	tx_clk_100_a: assert property (@(posedge i_mclk) disable iff (i_rst)
		$rose(o_tx_clk) && s100_s && $past(s100_s) |-> o_tx_clk [*2] ##1 !o_tx_clk)
		else $error("transmit clock high phase wrong at 100M");
	tx_clk_10_a: assert property (@(posedge i_mclk) disable iff (i_rst)
		$rose(o_tx_clk) && !s100_s && $past(!s100_s) |-> ##(HALF_10 - 1) o_tx_clk ##1 !o_tx_clk)
		else $error("transmit clock high phase wrong at 10M");
	rx_clk_100_a: assert property (@(posedge i_mclk) disable iff (i_rst)
		$rose(o_rx_clk) && s100_s && st_r.rx_busy && lra_s |-> ##1 o_rx_clk ##1 !o_rx_clk)
		else $error("receive clock high phase wrong at 100M");
	rx_data_edge_a: assert property (@(posedge i_mclk) disable iff (i_rst)
		$changed(o_rxd) || $changed(o_rx_dv) |-> $fell(o_rx_clk))
		else $error("receive outputs moved off the falling edge");
	mdio_update_a: assert property (@(posedge i_mclk) disable iff (i_rst)
		$changed(o_mdio_o) || $changed(o_mdio_oe) |-> $past(mdc_rise))
		else $error("management data changed without a clock rise");
	mdio_valid_a: assert property (@(posedge i_mclk) disable iff (i_rst)
		mdc_rise && st_r.mst == mpst_pkg::MPST_M_TA && st_r.mrd |-> ##[1:MDIO_CYC] o_mdio_oe)
		else $error("read data not driven in time");
	line_first_bit_a: assert property (@(posedge i_mclk) disable iff (i_rst)
		tx_take && tx_en_s |-> ##1 o_line_transmit_pair_en
			&& (o_line_transmit_pair == $past(txd_s[0])))
		else $error("first transmit bit late or wrong");
	crs_on_100_a: assert property (@(posedge i_mclk) disable iff (i_rst)
		s100_s && hdx_s && tx_take && tx_en_s |-> ##[1:4] o_crs)
		else $error("carrier sense late at 100M");
	crs_off_a: assert property (@(posedge i_mclk) disable iff (i_rst)
		hdx_s && $fell(tx_en_s) && !lra_s |-> ##[0:1] !o_crs)
		else $error("carrier sense held after transmit end");
	crs_on_10_a: assert property (@(posedge i_mclk) disable iff (i_rst)
		!s100_s && hdx_s && $rose(tx_en_s) |-> ##[0:17] o_crs)
		else $error("carrier sense late at 10M");
	rx_latency_a: assert property (@(posedge i_mclk) disable iff (i_rst)
		!s100_s && $rose(st_r.rx_busy) |-> ##[1:60] (o_rx_dv || !st_r.rx_busy))
		else $error("receive nibble late at 10M");
	bit_time_10_a: assert property (@(posedge i_mclk) disable iff (i_rst)
		bit_en && !s100_s && $past(!s100_s) |-> ##10 (bit_en || s100_s))
		else $error("10M bit time wrong");

endmodule

`default_nettype wire

// [dv/mpst_mac_model.sv]
`default_nettype none

// ----------------------------------------------------------------------
// MAC and station model
// ----------------------------------------------------------------------
module mpst_mac_model (
	// Clock
	input  wire logic       i_mclk,
	// MII transmit
	input  wire logic       i_tx_clk,
	output logic      [3:0] o_txd,
	output logic            o_tx_en,
	output logic            o_tx_er,
	// Management
	output logic            o_mdc,
	output logic            o_mdio_i,
	input  wire logic       i_mdio_o,
	input  wire logic       i_mdio_oe
);
	timeunit 1ns;
	timeprecision 1ns;

	logic sta_o;
	logic sta_oe;

	// Wire level: device, else station, else the pull-up
	assign o_mdio_i = i_mdio_oe ? i_mdio_o : (sta_oe ? sta_o : 1'b1);

	initial begin
		o_txd  = 4'h0;
		o_tx_en = 1'b0;
		o_tx_er = 1'b0;
		o_mdc  = 1'b0;
		sta_o  = 1'b1;
		sta_oe = 1'b0;
	end

	// Waits at falling mclk edges until the transmit clock has risen
	task automatic wait_rise();
		logic q;
		do begin
			q = i_tx_clk;
			@(negedge i_mclk);
		end while (!(i_tx_clk && !q));
	endtask

	// Nibbles change just after each rise, so the hold is a whole period
	task automatic send_frame(input int n);
		for (int i = 0; i <= n; i++) begin
			wait_rise();
			o_txd   = 4'($urandom);
			o_tx_en = (i < n);
			o_tx_er = ($urandom % 6) == 0;
		end
	endtask

	// One frame; the station lets go of the line from turnaround on reads
	task automatic mgmt(input logic [1:0] op, output logic [63:0] oe_s,
			output logic [63:0] d_s);
		logic [63:0] tx;
		tx = {32'hFFFF_FFFF, 2'b01, op, 10'($urandom), 2'b10, 16'($urandom)};
		for (int i = 63; i >= 0; i--) begin
			sta_o  = tx[i];
			sta_oe = (op != 2'b10) || (i > 17);
			repeat (10) @(negedge i_mclk);
			o_mdc = 1'b1;
			repeat (20) @(negedge i_mclk);
			o_mdc = 1'b0;
			repeat (10) @(negedge i_mclk);
			oe_s[i] = i_mdio_oe;
			d_s[i]  = o_mdio_i;
		end
		sta_oe = 1'b0;
	endtask

endmodule

`default_nettype wire

// [dv/tb_mpst_top.sv]
`default_nettype none

module tb_mpst_top;
	timeunit 1ns;
	timeprecision 1ns;

	// ------------------------------------------------------------------
	// Signals and bench state
	// ------------------------------------------------------------------
	logic        i_mclk, i_rst, s100, hdx, tx_clk, tx_en, tx_er, rx_clk;
	logic        rx_dv, rx_er, crs, lt, lt_en, lt_err, lr, lr_act, lr_err;
	logic        mdc, mdio_i, mdio_o, mdio_oe, txc_q, rxc_q, first_pend;
	logic [3:0]  txd, rxd;
	logic [5:0]  pin_q, ex_nib, rx_q;
	logic [4:0]  rx_exp[$];
	logic [63:0] oe_s, d_s;
	int          n_mismatch, cmp_count, cyc, bc, tp, rp, bcnt, crs_cd, t_first;

	mpst_top i_mpst_top (
		.i_mclk(i_mclk), .i_rst(i_rst), .i_speed_100(s100), .i_half_duplex(hdx),
		.o_tx_clk(tx_clk), .i_txd(txd), .i_tx_en(tx_en), .i_tx_er(tx_er),
		.o_rx_clk(rx_clk), .o_rxd(rxd), .o_rx_dv(rx_dv), .o_rx_er(rx_er), .o_crs(crs),
		.o_line_transmit_pair(lt), .o_line_transmit_pair_en(lt_en),
		.o_line_transmit_pair_err(lt_err), .i_line_receive_pair(lr),
		.i_line_receive_pair_act(lr_act), .i_line_receive_pair_err(lr_err),
		.i_mdc(mdc), .i_mdio_i(mdio_i), .o_mdio_o(mdio_o), .o_mdio_oe(mdio_oe));

	mpst_mac_model i_mpst_mac_model (
		.i_mclk(i_mclk), .i_tx_clk(tx_clk), .o_txd(txd), .o_tx_en(tx_en),
		.o_tx_er(tx_er), .o_mdc(mdc), .o_mdio_i(mdio_i), .i_mdio_o(mdio_o),
		.i_mdio_oe(mdio_oe));

	// ------------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------------
	task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t %s seen %h exp %h", $time, what, seen, exp);
		end
	endtask

	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// Mode pins only change under reset, so no frame sees a switch
	task automatic do_reset(input logic sp, input logic hd);
		i_rst = 1'b1;
		s100  = sp;
		hdx   = hd;
		repeat (20) @(negedge i_mclk);
		bc    = sp ? 1 : 10;
		tp    = -1;
		rp    = -1;
		i_rst = 1'b0;
	endtask

	// Serial frame, first bit into nibble bit 0, sparse symbol errors
	task automatic rx_frame(input int n);
		logic [3:0] nib, ev;
		first_pend = 1'b1;
		t_first    = cyc;
		for (int i = 0; i < n; i++) begin
			nib = 4'($urandom);
			ev  = ($urandom % 4 == 0) ? 4'($urandom) : 4'h0;
			rx_exp.push_back({nib, |ev});
			for (int b = 0; b < 4; b++) begin
				lr_act = 1'b1;
				lr     = nib[b];
				lr_err = ev[b];
				repeat (bc) @(negedge i_mclk);
			end
		end
		lr_act = 1'b0;
		lr     = ~lr;
		lr_err = 1'b0;
		repeat (12 * bc) @(negedge i_mclk);
		check(64'(rx_exp.size()), 64'h0, "rx nibbles left");
	endtask

	// ------------------------------------------------------------------
	// Monitors: pins seen at rise edges, outputs at falling edges
	// ------------------------------------------------------------------
	always @(posedge i_mclk) begin
		cyc   <= cyc + 1;
		pin_q <= {tx_en, tx_er, txd};
		if (tx_en !== pin_q[5]) crs_cd <= tx_en ? (s100 ? 8 : 2 * bc) : 4 * bc;
		else if (crs_cd > 0) crs_cd <= crs_cd - 1;
		if (cyc == 40000) begin
			n_mismatch++;
			tally_and_finish();
		end
	end

	always @(negedge i_mclk) begin
		if (!i_rst) begin
			tp = (tp < 0) ? tp : tp + 1;
			rp = (rp < 0 || lr_act) ? -1 : rp + 1;
			if (tx_clk && !txc_q) begin
				if (tp >= 0) check(64'(tp), 64'(4 * bc), "tx period");
				tp     = 0;
				bcnt   = 0;
				ex_nib = pin_q;
				check(64'({lt_en, lt_err}), 64'({pin_q[5], &pin_q[5:4]}), "line flags");
			end
			if (ex_nib[5] && bcnt % bc == 0 && bcnt < 4 * bc)
				check(64'(lt), 64'(ex_nib[bcnt / bc]), "line bit");
			if (rx_clk && !rxc_q) begin
				if (rp >= 0) check(64'(rp), 64'(4 * bc), "rx period");
				rp = 0;
				if (rx_dv && rx_exp.size() == 0) check(64'(rx_dv), 64'h0, "extra nibble");
				else if (rx_dv) check(64'({rxd, rx_er}), 64'(rx_exp.pop_front()), "rx nibble");
			end
			if (!rx_clk && rxc_q && rx_dv && first_pend && !s100) begin
				check(64'(cyc - t_first <= 7 * bc), 64'h1, "rx latency");
				first_pend = 1'b0;
			end
			if (rx_clk) check(64'({rxd, rx_dv, rx_er}), 64'(rx_q), "rx held");
			if (crs_cd == 1) check(64'(crs), 64'(pin_q[5] & hdx), "carrier");
			bcnt++;
		end
		txc_q = tx_clk;
		rxc_q = rx_clk;
		rx_q  = {rxd, rx_dv, rx_er};
	end

	// ------------------------------------------------------------------
	// Clock and main sequence
	// ------------------------------------------------------------------
	initial begin
		i_mclk = 1'b0;
		forever #5 i_mclk = ~i_mclk;
	end

	initial begin
		i_rst      = 1'b1;
		s100       = 1'b0;
		hdx        = 1'b0;
		lr         = 1'b0;
		lr_act     = 1'b0;
		lr_err     = 1'b0;
		first_pend = 1'b0;
		ex_nib     = 6'h00;
		cyc        = 0;
		crs_cd     = 0;
		void'($urandom(37080));
		// Every speed and duplex pairing: transmit, receive, management
		for (int m = 0; m < 4; m++) begin
			do_reset(m[0], m[1]);
			repeat (40 * bc) @(negedge i_mclk);
			i_mpst_mac_model.send_frame(12);
			repeat (8 * bc) @(negedge i_mclk);
			rx_frame(8);
			for (int op = 1; op <= 2; op++) begin
				i_mpst_mac_model.mgmt(2'(op), oe_s, d_s);
				check(oe_s, (op == 2) ? 64'h0000_0000_0003_FFFE : 64'h0, "mdio enable");
				if (op == 2)
					check(64'(d_s[17:1]), 64'({1'b0, s100, hdx, 14'h0000}), "mdio data");
			end
			$display("mode %0d done", m);
		end
		tally_and_finish();
	end

endmodule

`default_nettype wire
